// ==== uart_status_flags.sv ====
// status register of the asynchronous serial port with its control bits and interrupt
//
// Functional notes
// - the 8-bit status byte holds the transfer flag in bit 7, parity error in bit 2, framing in 1, overrun in 0, bits 6..3 zero.
// - the status byte may be accessed as a whole byte or one bit at a time.
// - the transfer-in-progress flag is read-only and writes never change it.
// - writing 0 clears an error flag, writing 1 leaves it as it is, so software can never set one.
// - reset and a cleared port power control initialize the whole status byte.
// - the transfer flag is held clear while port power or transmit enable is 0.
// - a transmit data write sets the transfer flag; a finished transfer with nothing waiting clears it.
// - a received frame whose parity bit disagrees with the expected bit of the selected parity mode sets the parity error flag; mode none never flags.
// - the error flags are held clear while port power or receive enable is 0.
// - a received frame without a valid stop bit sets the framing error flag.
`timescale 1ns/1ns
`default_nettype none
`include "uart_status_flags_map.svh"
module uart_status_flags
    import uart_status_flags_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic bit_access_in,
    input wire logic [2:0] bit_index_in,
    input wire logic tx_data_write_in,
    input wire logic tx_done_in,
    input wire logic tx_next_pending_in,
    input wire logic rx_valid_in,
    input wire logic [7:0] rx_data_in,
    input wire logic rx_parity_bit_in,
    input wire logic rx_stop_bit_in,
    input wire logic rx_overrun_in,
    output logic [7:0] rdata_out,
    output logic irq_out,
    output logic port_power_out,
    output logic tx_enable_out,
    output logic rx_enable_out,
    output logic [1:0] parity_mode_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // request grouping and decode

    bus_req_t req;
    rx_frame_t frame;
    logic [7:0] lane;
    logic wr_status, wr_control, wr_int_status, wr_int_mask;

    always_comb begin
        req.wr = wr_in;
        req.rd = rd_in;
        req.addr = addr_in;
        req.wdata = wdata_in;
        req.bit_access = bit_access_in;
        req.bit_index = bit_index_in;
        frame.valid = rx_valid_in;
        frame.data = rx_data_in;
        frame.parity_bit = rx_parity_bit_in;
        frame.stop_bit = rx_stop_bit_in;
    end

    assign lane = access_mask(req.bit_access, req.bit_index);
    assign wr_status = req.wr && (req.addr == `OFS_STATUS);
    assign wr_control = req.wr && (req.addr == `OFS_CONTROL);
    assign wr_int_status = req.wr && (req.addr == `OFS_INT_STATUS);
    assign wr_int_mask = req.wr && (req.addr == `OFS_INT_MASK);

    ////////////////////////////////////////////////////////////////////////////////
    // control bits

    ctrl_t ctrl_q, ctrl_d;

    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_control) begin
            ctrl_d = ctrl_t'(((ctrl_q & ~lane) | (req.wdata & lane)) & `CTRL_WMASK);
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_q <= ctrl_t'(`CTRL_RESET);
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status byte

    status_t st_q, st_d;
    logic par_mismatch;
    logic on_tx, on_rx;
    logic pe_ev, fe_ev, ove_ev, txdone_ev;

    parity_check u_parity (
        .parity_mode_in(ctrl_q.parity_mode),
        .data_in(frame.data),
        .parity_bit_in(frame.parity_bit),
        .mismatch_out(par_mismatch)
    );

    assign on_tx = ctrl_q.port_power_control && ctrl_q.transmit_enable_control;
    assign on_rx = ctrl_q.port_power_control && ctrl_q.receive_enable_control;
    assign pe_ev = on_rx && frame.valid && par_mismatch;
    assign fe_ev = on_rx && frame.valid && !frame.stop_bit;
    assign ove_ev = on_rx && rx_overrun_in;
    assign txdone_ev = on_tx && st_q.transfer_in_progress_flag && tx_done_in && !tx_next_pending_in
        && !tx_data_write_in;

    always_comb begin
        st_d = st_q;
        // software may only clear error bits, never set them; bit 7 ignores writes
        if (wr_status) begin
            st_d.parity_error_flag = st_q.parity_error_flag & ~(lane[`BIT_PE] & ~req.wdata[`BIT_PE]);
            st_d.framing_error_flag = st_q.framing_error_flag & ~(lane[`BIT_FE] & ~req.wdata[`BIT_FE]);
            st_d.overrun_error_flag = st_q.overrun_error_flag & ~(lane[`BIT_OVE] & ~req.wdata[`BIT_OVE]);
        end
        // hardware sets win over a clear in the same cycle; good frames never clear
        if (pe_ev) begin
            st_d.parity_error_flag = 1'b1;
        end
        if (fe_ev) begin
            st_d.framing_error_flag = 1'b1;
        end
        if (ove_ev) begin
            st_d.overrun_error_flag = 1'b1;
        end
        if (tx_done_in && !tx_next_pending_in) begin
            st_d.transfer_in_progress_flag = 1'b0;
        end
        if (tx_data_write_in) begin
            st_d.transfer_in_progress_flag = 1'b1;
        end
        if (!ctrl_q.transmit_enable_control) begin
            st_d.transfer_in_progress_flag = 1'b0;
        end
        if (!ctrl_q.receive_enable_control) begin
            st_d.parity_error_flag = 1'b0;
            st_d.framing_error_flag = 1'b0;
            st_d.overrun_error_flag = 1'b0;
        end
        if (!ctrl_q.port_power_control) begin
            st_d = status_t'(`STATUS_RESET);
        end
        st_d.zero = 4'h0;
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_q <= status_t'(`STATUS_RESET);
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt

    logic [3:0] events;
    logic [3:0] int_status, int_mask;

    always_comb begin
        events = 4'h0;
        events[`INT_OVE] = ove_ev;
        events[`INT_FE] = fe_ev;
        events[`INT_PE] = pe_ev;
        events[`INT_TXDONE] = txdone_ev;
    end

    irq_unit u_irq (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .event_in(events),
        .status_wr_in(wr_int_status),
        .mask_wr_in(wr_int_mask),
        .wdata_in(req.wdata[3:0]),
        .lane_in(lane[3:0]),
        .int_status_out(int_status),
        .int_mask_out(int_mask),
        .irq_out(irq_out)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // read data, valid only in the cycle after the read strobe

    logic [7:0] rdata_q, rdata_d;

    always_comb begin
        rdata_d = 8'h00;
        if (req.rd) begin
            case (req.addr)
                `OFS_STATUS: rdata_d = st_q;
                `OFS_CONTROL: rdata_d = ctrl_q;
                `OFS_INT_STATUS: rdata_d = {4'h0, int_status};
                `OFS_INT_MASK: rdata_d = {4'h0, int_mask};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_out = rdata_q;
    assign port_power_out = ctrl_q.port_power_control;
    assign tx_enable_out = ctrl_q.transmit_enable_control;
    assign rx_enable_out = ctrl_q.receive_enable_control;
    assign parity_mode_out = ctrl_q.parity_mode;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rstn_in);

    a_status_read_layout: assert property (
        req.rd && req.addr == `OFS_STATUS |=> rdata_out[6:3] == 4'h0 && rdata_out[7] == $past(st_q[7])
            && rdata_out[2:0] == $past(st_q[2:0]))
        else $error("status read does not show the status layout");

    a_bit_write_others: assert property (
        wr_status && req.bit_access && req.bit_index != 3'h2 && st_q.parity_error_flag && on_rx
            |=> st_q.parity_error_flag)
        else $error("single-bit write disturbed another flag");

    a_tsf_read_only: assert property (
        wr_status && on_tx && !tx_data_write_in && !tx_done_in
            |=> $stable(st_q.transfer_in_progress_flag))
        else $error("write changed the transfer flag");

    a_err_write_zero: assert property (
        wr_status && !req.bit_access && !req.wdata[`BIT_FE] && !fe_ev |=> !st_q.framing_error_flag)
        else $error("writing zero did not clear the framing flag");

    a_err_write_one: assert property (
        wr_status && req.wdata[`BIT_OVE] && !st_q.overrun_error_flag && !ove_ev
            |=> !st_q.overrun_error_flag)
        else $error("writing one set the overrun flag");

    a_power_off_init: assert property (
        !ctrl_q.port_power_control |=> st_q == status_t'(`STATUS_RESET))
        else $error("status not initialized while power is off");

    a_txe_off_clear: assert property (
        !ctrl_q.transmit_enable_control |=> !st_q.transfer_in_progress_flag)
        else $error("transfer flag set while transmit is disabled");

    a_tsf_set_write: assert property (
        on_tx && tx_data_write_in |=> st_q.transfer_in_progress_flag)
        else $error("transmit write did not set the transfer flag");

    a_tsf_clear_done: assert property (
        on_tx && tx_done_in && !tx_next_pending_in && !tx_data_write_in |=> !st_q.transfer_in_progress_flag)
        else $error("finished transfer did not clear the transfer flag");

    a_parity_set: assert property (
        on_rx && frame.valid && par_mismatch |=> st_q.parity_error_flag)
        else $error("parity mismatch not flagged");

    a_rxe_off_clear: assert property (
        !ctrl_q.receive_enable_control |=> st_q[2:0] == 3'h0)
        else $error("error flags set while receive is disabled");

    a_framing_set: assert property (
        on_rx && frame.valid && !frame.stop_bit |=> st_q.framing_error_flag)
        else $error("missing stop bit not flagged");

    a_err_sticky: assert property (
        st_q.parity_error_flag && on_rx && !wr_status && !wr_control
            |=> st_q.parity_error_flag [*1] ##1 (st_q.parity_error_flag || $past(wr_status) || $past(wr_control)
                || !$past(on_rx)))
        else $error("parity flag dropped without a clear");

    a_irq_level: assert property (
        irq_out == |($past(int_status) & $past(int_mask)) || $past(events) != 4'h0 || $past(wr_int_status)
            || $past(wr_int_mask))
        else $error("interrupt output disagrees with masked status");

    a_set_beats_clear: assert property (
        fe_ev && wr_status |=> st_q.framing_error_flag)
        else $error("framing event lost to a software clear");

    a_overrun_set: assert property (
        ove_ev |=> st_q.overrun_error_flag)
        else $error("overrun not flagged");

    c_tx_cycle: cover property (on_tx && tx_data_write_in ##[1:20] txdone_ev);
    c_parity_err: cover property (pe_ev ##[1:10] wr_status && !req.wdata[`BIT_PE]);
    c_set_beats_clear: cover property (fe_ev && wr_status && !req.wdata[`BIT_FE]);
    c_irq_raised: cover property (!irq_out ##1 irq_out);

endmodule // uart_status_flags
`default_nettype wire

// ==== uart_status_flags_map.svh ====
// register offsets, field positions and reset values of the serial port status block
`ifndef UART_STATUS_FLAGS_MAP_SVH
`define UART_STATUS_FLAGS_MAP_SVH

`define OFS_STATUS 8'h00
`define OFS_CONTROL 8'h04
`define OFS_INT_STATUS 8'h08
`define OFS_INT_MASK 8'h0c

`define BIT_TSF 7
`define BIT_PE 2
`define BIT_FE 1
`define BIT_OVE 0
`define STATUS_RESET 8'h00
`define STATUS_ERR_MASK 8'h07

`define CTRL_RESET 8'h00
`define CTRL_WMASK 8'h1f
`define PAR_NONE 2'h0
`define PAR_EVEN 2'h1
`define PAR_ODD 2'h2
`define PAR_ZERO 2'h3

`define INT_OVE 0
`define INT_FE 1
`define INT_PE 2
`define INT_TXDONE 3
`define INT_RESET 4'h0

`endif

// ==== uart_status_flags_pkg.sv ====
// types shared by the serial port status block
`default_nettype none
package uart_status_flags_pkg;

    typedef struct packed {
        logic transfer_in_progress_flag;
        logic [3:0] zero;
        logic parity_error_flag;
        logic framing_error_flag;
        logic overrun_error_flag;
    } status_t;

    typedef struct packed {
        logic [2:0] zero;
        logic [1:0] parity_mode;
        logic receive_enable_control;
        logic transmit_enable_control;
        logic port_power_control;
    } ctrl_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic parity_bit;
        logic stop_bit;
    } rx_frame_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic bit_access;
        logic [2:0] bit_index;
    } bus_req_t;

    // lanes touched by an access: whole byte, or the single addressed bit
    function automatic logic [7:0] access_mask(input logic bit_access, input logic [2:0] bit_index);
        logic [7:0] m;
        m = 8'hff;
        if (bit_access) begin
            m = 8'h01 << bit_index;
        end
        return m;
    endfunction

endpackage
`default_nettype wire

// ==== parity_check.sv ====
// compares the parity bit of a received frame against the expected bit of the selected mode: the data parity for even, its inverse for odd, 0 for zero
`timescale 1ns/1ns
`default_nettype none
`include "uart_status_flags_map.svh"
module parity_check
    import uart_status_flags_pkg::*;
(
    input wire logic [1:0] parity_mode_in,
    input wire logic [7:0] data_in,
    input wire logic parity_bit_in,
    output logic mismatch_out
);
    logic expected;

    always_comb begin
        expected = 1'b0;
        case (parity_mode_in)
            `PAR_EVEN: expected = ^data_in;
            `PAR_ODD: expected = ~(^data_in);
            `PAR_ZERO: expected = 1'b0;
            default: expected = parity_bit_in;
        endcase
        // no parity selected: never a mismatch
        mismatch_out = (parity_mode_in != `PAR_NONE) && (expected != parity_bit_in);
    end
endmodule // parity_check
`default_nettype wire

// ==== irq_unit.sv ====
// sticky event bits, mask and level interrupt output
`timescale 1ns/1ns
`default_nettype none
`include "uart_status_flags_map.svh"
module irq_unit
    import uart_status_flags_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic [3:0] event_in,
    input wire logic status_wr_in,
    input wire logic mask_wr_in,
    input wire logic [3:0] wdata_in,
    input wire logic [3:0] lane_in,
    output logic [3:0] int_status_out,
    output logic [3:0] int_mask_out,
    output logic irq_out
);
    logic [3:0] ist_q, ist_d, msk_q, msk_d;
    logic irq_q, irq_d;

    always_comb begin
        ist_d = ist_q;
        msk_d = msk_q;
        if (status_wr_in) begin
            ist_d = ist_q & ~(wdata_in & lane_in);
        end
        // a new event wins over a clear in the same cycle
        ist_d = ist_d | event_in;
        if (mask_wr_in) begin
            msk_d = (msk_q & ~lane_in) | (wdata_in & lane_in);
        end
        irq_d = |(ist_d & msk_d);
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ist_q <= `INT_RESET;
            msk_q <= `INT_RESET;
            irq_q <= 1'b0;
        end else begin
            ist_q <= ist_d;
            msk_q <= msk_d;
            irq_q <= irq_d;
        end
    end

    assign int_status_out = ist_q;
    assign int_mask_out = msk_q;
    assign irq_out = irq_q;
endmodule // irq_unit
`default_nettype wire

// ==== test_uart_status_flags.sv ====
// self-checking testbench of the serial port status block
`timescale 1ns/1ns
`default_nettype none
`include "uart_status_flags_map.svh"
module test_uart_status_flags;
    import uart_status_flags_pkg::*;

    logic ref_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic bit_access_in = 1'b0;
    logic [2:0] bit_index_in = 3'h0;
    logic tx_data_write_in = 1'b0;
    logic tx_done_in = 1'b0;
    logic tx_next_pending_in = 1'b0;
    logic rx_valid_in = 1'b0;
    logic [7:0] rx_data_in = 8'h00;
    logic rx_parity_bit_in = 1'b0;
    logic rx_stop_bit_in = 1'b1;
    logic rx_overrun_in = 1'b0;
    logic [7:0] rdata_out;
    logic irq_out;
    logic port_power_out;
    logic tx_enable_out;
    logic rx_enable_out;
    logic [1:0] parity_mode_out;
    int miscompares = 0;
    int total_checks = 0;

    uart_status_flags dut_u (
        .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .bit_access_in(bit_access_in), .bit_index_in(bit_index_in),
        .tx_data_write_in(tx_data_write_in), .tx_done_in(tx_done_in),
        .tx_next_pending_in(tx_next_pending_in), .rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in),
        .rx_parity_bit_in(rx_parity_bit_in), .rx_stop_bit_in(rx_stop_bit_in),
        .rx_overrun_in(rx_overrun_in), .rdata_out(rdata_out), .irq_out(irq_out),
        .port_power_out(port_power_out), .tx_enable_out(tx_enable_out),
        .rx_enable_out(rx_enable_out), .parity_mode_out(parity_mode_out)
    );

    always #50 ref_clk_in = ~ref_clk_in;

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic bit_acc = 1'b0,
                      input logic [2:0] idx = 3'h0);
        @(posedge ref_clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        bit_access_in <= bit_acc;
        bit_index_in <= idx;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
        bit_access_in <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge ref_clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out, exp, what);
    endtask

    // one-cycle event pulse: 0 tx write, 1 tx done, 2 overrun
    task automatic ev(input int which, input logic pending = 1'b0);
        @(posedge ref_clk_in);
        tx_data_write_in <= (which == 0);
        tx_done_in <= (which == 1);
        tx_next_pending_in <= pending;
        rx_overrun_in <= (which == 2);
        @(posedge ref_clk_in);
        tx_data_write_in <= 1'b0;
        tx_done_in <= 1'b0;
        rx_overrun_in <= 1'b0;
        #1;
    endtask

    task automatic frm(input logic [7:0] d, input logic par, input logic stop);
        @(posedge ref_clk_in);
        rx_valid_in <= 1'b1;
        rx_data_in <= d;
        rx_parity_bit_in <= par;
        rx_stop_bit_in <= stop;
        @(posedge ref_clk_in);
        rx_valid_in <= 1'b0;
        rx_stop_bit_in <= 1'b1;
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd_chk(`OFS_STATUS, 8'h00, "status after reset");
        rd_chk(`OFS_CONTROL, 8'h00, "control after reset");
        ev(0);
        ev(2);
        rd_chk(`OFS_STATUS, 8'h00, "events with power off");
        rd_chk(`OFS_INT_STATUS, 8'h00, "no int while off");
        $display("test reset done");
    endtask

    task automatic t_transfer;
        wr(`OFS_CONTROL, 8'h07);
        wr(`OFS_INT_MASK, 8'h0f);
        ev(0);
        rd_chk(`OFS_STATUS, 8'h80, "flag set by tx write");
        wr(`OFS_STATUS, 8'h00);
        rd_chk(`OFS_STATUS, 8'h80, "flag ignores byte write");
        wr(`OFS_STATUS, 8'hff);
        rd_chk(`OFS_STATUS, 8'h80, "ones cannot set errors");
        wr(`OFS_STATUS, 8'h00, 1'b1, 3'h7);
        rd_chk(`OFS_STATUS, 8'h80, "flag ignores bit write");
        ev(1, 1'b1);
        rd_chk(`OFS_STATUS, 8'h80, "done with data waiting");
        chk({7'h00, irq_out}, 8'h00, "no irq yet");
        ev(1);
        chk({7'h00, irq_out}, 8'h01, "irq on tx done");
        rd_chk(`OFS_STATUS, 8'h00, "done with nothing waiting");
        rd_chk(`OFS_INT_STATUS, 8'h08, "tx done int bit");
        wr(`OFS_INT_STATUS, 8'h08);
        chk({7'h00, irq_out}, 8'h00, "irq cleared");
        $display("test transfer done");
    endtask

    task automatic t_errors;
        wr(`OFS_CONTROL, 8'h0f);
        frm(8'h00, 1'b0, 1'b0);
        rd_chk(`OFS_STATUS, 8'h02, "framing error");
        ev(2);
        rd_chk(`OFS_STATUS, 8'h03, "overrun error");
        frm(8'h01, 1'b0, 1'b1);
        rd_chk(`OFS_STATUS, 8'h07, "parity error");
        frm(8'h03, 1'b0, 1'b1);
        rd_chk(`OFS_STATUS, 8'h07, "good frame keeps flags");
        wr(`OFS_STATUS, 8'hff);
        rd_chk(`OFS_STATUS, 8'h07, "ones written keep flags");
        wr(`OFS_STATUS, 8'hfd, 1'b1, 3'h1);
        rd_chk(`OFS_STATUS, 8'h05, "bit write clears framing");
        rd_chk(`OFS_INT_STATUS, 8'h07, "error int bits");
        chk({7'h00, irq_out}, 8'h01, "irq on errors");
        wr(`OFS_STATUS, 8'h00);
        rd_chk(`OFS_STATUS, 8'h00, "zero write clears all");
        wr(`OFS_INT_STATUS, 8'h07);
        chk({7'h00, irq_out}, 8'h00, "irq cleared");
        $display("test errors done");
    endtask

    task automatic t_parity_modes;
        logic [1:0] m;
        for (int i = 0; i < 4; i++) begin
            m = i[1:0];
            wr(`OFS_CONTROL, {3'h0, m, 3'h7});
            chk({6'h00, parity_mode_out}, {6'h00, m}, "parity mode out");
            frm(8'h00, 1'b1, 1'b1);
            rd_chk(`OFS_STATUS, {5'h00, m[0], 2'h0}, "parity per mode");
            wr(`OFS_STATUS, 8'h00);
        end
        wr(`OFS_INT_STATUS, 8'h0f);
        $display("test parity modes done");
    endtask

    task automatic t_disable;
        wr(`OFS_CONTROL, 8'h07);
        ev(0);
        ev(2);
        rd_chk(`OFS_STATUS, 8'h81, "flags set");
        wr(`OFS_CONTROL, 8'h03);
        chk({5'h00, rx_enable_out, tx_enable_out, port_power_out}, 8'h03, "enable outputs");
        rd_chk(`OFS_STATUS, 8'h80, "rx off clears errors");
        ev(2);
        rd_chk(`OFS_STATUS, 8'h80, "overrun ignored with rx off");
        wr(`OFS_CONTROL, 8'h07);
        ev(2);
        wr(`OFS_CONTROL, 8'h05);
        rd_chk(`OFS_STATUS, 8'h01, "tx off clears flag");
        ev(0);
        rd_chk(`OFS_STATUS, 8'h01, "tx write ignored with tx off");
        wr(`OFS_CONTROL, 8'h07);
        ev(0);
        wr(`OFS_CONTROL, 8'h06);
        rd_chk(`OFS_STATUS, 8'h00, "power off clears all");
        rd_chk(`OFS_CONTROL, 8'h06, "control readback");
        chk({5'h00, rx_enable_out, tx_enable_out, port_power_out}, 8'h06, "power output off");
        wr(`OFS_INT_STATUS, 8'h0f);
        $display("test disable done");
    endtask

    task automatic t_mask_unmapped;
        wr(`OFS_CONTROL, 8'h07);
        wr(`OFS_INT_MASK, 8'h00);
        ev(2);
        chk({7'h00, irq_out}, 8'h00, "masked event gives no irq");
        rd_chk(`OFS_INT_STATUS, 8'h01, "int status still set");
        wr(`OFS_INT_MASK, 8'h01);
        chk({7'h00, irq_out}, 8'h01, "unmask raises irq");
        wr(8'h10, 8'hff);
        rd_chk(8'h10, 8'h00, "unmapped read");
        rd_chk(`OFS_STATUS, 8'h01, "unmapped write harmless");
        wr(`OFS_INT_STATUS, 8'h01);
        chk({7'h00, irq_out}, 8'h00, "irq cleared");
        $display("test mask and unmapped done");
    endtask

    // a missing stop bit and a zero write to the status byte in one cycle: the event wins
    task automatic t_set_wins;
        wr(`OFS_CONTROL, 8'h07);
        @(posedge ref_clk_in);
        wr_in <= 1'b1;
        addr_in <= `OFS_STATUS;
        wdata_in <= 8'h00;
        rx_valid_in <= 1'b1;
        rx_data_in <= 8'h00;
        rx_stop_bit_in <= 1'b0;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
        rx_valid_in <= 1'b0;
        rx_stop_bit_in <= 1'b1;
        #1;
        rd_chk(`OFS_STATUS, 8'h02, "event beats clear");
        rd_chk(`OFS_INT_STATUS, 8'h02, "framing int bit");
        wr(`OFS_STATUS, 8'h00);
        wr(`OFS_INT_STATUS, 8'h0f);
        $display("test set wins done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        miscompares++;
        $display("BAD t=%0t watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        repeat (2) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        t_reset();
        t_transfer();
        t_errors();
        t_parity_modes();
        t_disable();
        t_mask_unmapped();
        t_set_wins();
        tally_and_finish();
    end

endmodule // test_uart_status_flags
`default_nettype wire
